// File: pkg/cldi_defines.svh
`ifndef CLDI_DEFINES_SVH
`define CLDI_DEFINES_SVH

// Fixed transition window between leaving idle and reaching pick-up.
`define CLDI_RISE_WINDOW_MS     80
// Period of the measurement tick from the front end, in microseconds.
`define CLDI_TICK_PERIOD_US     10000
// Rise window in ticks; a longest time, so it rounds down.
`define CLDI_RISE_TICKS         ((`CLDI_RISE_WINDOW_MS * 1000) / `CLDI_TICK_PERIOD_US)
// Ticks in one second, used to turn the maximum active time into ticks.
`define CLDI_TICKS_PER_SEC      (1000000 / `CLDI_TICK_PERIOD_US)
// Ticks in one full power cycle (20 ms at 50 Hz).
`define CLDI_CYCLE_TICKS        2
// Reset values of the settings; idle and pick-up are Q8.8 multiples of nominal.
`define CLDI_IDLE_RST           16'h0020
`define CLDI_PICKUP_RST         16'h0180
`define CLDI_MAX_TIME_RST       16'h0001
`define CLDI_HARM_THR_RST       8'h14
// Fraction bits of the relative thresholds and currents.
`define CLDI_REL_FRAC           8

`endif

// File: pkg/cldi_pkg.sv
package cldi_pkg;

  // Reported status of one detection function.
  typedef enum logic [1:0] {
    CLDI_INACTIVE,
    CLDI_START,
    CLDI_TRIP
  } cldi_status_t;

  // Arming sequence shared by cold load and inrush.
  typedef enum logic [1:0] {
    CLDI_UNARMED,
    CLDI_ARMED,
    CLDI_RISING,
    CLDI_ENGAGED
  } cldi_arm_t;

endpackage

// File: pkg/cldi_stage_if.sv
`timescale 1ns/1ps
interface cldi_stage_if
  import cldi_pkg::*;
#(
  parameter int TW = 32
);
  logic               tick;
  logic               start;
  logic               keep;
  logic [TW-1:0]      max_ticks;
  logic               active;
  cldi_status_t       status;

  modport ctrl  (output tick, output start, output keep, output max_ticks,
                 input active, input status);
  modport stage (input tick, input start, input keep, input max_ticks,
                 output active, output status);
endinterface

// File: rtl/cldi_detector.sv
`timescale 1ns/1ps
`include "cldi_defines.svh"
// Notes on behaviour
// - Arm after all phases below idle; signal when pick-up reached within 80 ms.
// - Cold-load stays active until maximum time expires or current drops below pick-up.
// - Inrush needs the same idle-then-rise plus a phase harmonic ratio over threshold.
// - A zero harmonic threshold makes inrush behave exactly like cold load.
// - Inrush starts on the rise; after one cycle it continues only once a phase harmonic ratio has exceeded the threshold.
// - No activation if current never dropped below idle before rising.
// - Lingering between idle and pick-up over 80 ms abandons; re-arm needs idle again.
// - Each function reports inactive, start or trip status.
// - Supervised current is the largest of the three phase magnitudes.
// - Detection outputs are routable to output matrix and blocking matrix.
// - Thresholds relative to nominal, time in seconds; changes need the password.
// - Idle and pick-up thresholds are also shown in primary amperes.
module cldi_detector
  import cldi_pkg::*;
#(
  parameter int CW          = 16,
  parameter int HW          = 8,
  parameter int TW          = 32,
  parameter int RISE_TICKS  = `CLDI_RISE_TICKS,
  parameter int CYCLE_TICKS = `CLDI_CYCLE_TICKS,
  parameter int TICKS_PER_S = `CLDI_TICKS_PER_SEC
) (
  input  wire logic          i_ref_clk,
  input  wire logic          i_resetn,
  input  wire logic          i_meas_tick,
  input  wire logic [CW-1:0] i_phase_current_a,
  input  wire logic [CW-1:0] i_phase_current_b,
  input  wire logic [CW-1:0] i_phase_current_c,
  input  wire logic [HW-1:0] i_harm_ratio_a,
  input  wire logic [HW-1:0] i_harm_ratio_b,
  input  wire logic [HW-1:0] i_harm_ratio_c,
  input  wire logic [CW-1:0] i_nominal_primary_a,
  input  wire logic          i_password_ok,
  input  wire logic          i_set_we,
  input  wire logic [CW-1:0] i_set_idle,
  input  wire logic [CW-1:0] i_set_pickup,
  input  wire logic [15:0]   i_set_max_active_time,
  input  wire logic [HW-1:0] i_set_second_harmonic_threshold,
  input  wire logic [3:0]    i_route_en,
  output logic [CW-1:0]      o_max_phase_current,
  output logic [CW-1:0]      o_idle_primary,
  output logic [CW-1:0]      o_pickup_primary,
  output logic [CW-1:0]      o_idle_setting,
  output logic [CW-1:0]      o_pickup_setting,
  output logic [15:0]        o_max_active_time,
  output logic [HW-1:0]      o_second_harmonic_threshold,
  output cldi_status_t       o_cold_load_status,
  output cldi_status_t       o_inrush_status,
  output logic               o_cold_load,
  output logic               o_inrush,
  output logic               o_out_matrix_cold_load,
  output logic               o_out_matrix_inrush,
  output logic               o_block_matrix_cold_load,
  output logic               o_block_matrix_inrush
);

  localparam int RCW = $clog2(RISE_TICKS + 2);
  localparam int YCW = $clog2(CYCLE_TICKS + 2);
  localparam logic [RCW-1:0] RISE_LIM  = RCW'(RISE_TICKS);
  localparam logic [YCW-1:0] CYCLE_LIM = YCW'(CYCLE_TICKS);

  logic [CW-1:0]  idle_r;
  logic [CW-1:0]  pickup_r;
  logic [15:0]    max_time_r;
  logic [HW-1:0]  harm_thr_r;
  logic [CW-1:0]  imax_r;
  logic           imax_vld_r;
  logic [CW-1:0]  idle_prim_r;
  logic [CW-1:0]  pickup_prim_r;
  logic [TW-1:0]  max_ticks_r;
  cldi_arm_t      arm_r;
  logic [RCW-1:0] rise_cnt_r;
  logic [YCW-1:0] cycle_cnt_r;
  logic           harm_seen_r;
  logic [2:0]     harm_over;
  logic [HW-1:0]  harm_ph [3];
  logic [CW-1:0]  imax_nxt;
  logic           all_idle;
  logic           above_pickup;
  logic           trigger;
  logic           harm_ok;
  logic           in_first_cycle;

  cldi_stage_if #(.TW(TW)) cold_if ();
  cldi_stage_if #(.TW(TW)) inr_if ();

  // Settings change only with the password; a write without it is dropped.
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      idle_r     <= CW'(`CLDI_IDLE_RST);
      pickup_r   <= CW'(`CLDI_PICKUP_RST);
      max_time_r <= `CLDI_MAX_TIME_RST;
      harm_thr_r <= HW'(`CLDI_HARM_THR_RST);
    end else if (i_set_we && i_password_ok) begin
      idle_r     <= i_set_idle;
      pickup_r   <= i_set_pickup;
      max_time_r <= i_set_max_active_time;
      harm_thr_r <= i_set_second_harmonic_threshold;
    end
  end

  // Largest phase magnitude is the supervised value.
  always_comb begin
    imax_nxt = i_phase_current_a;
    if (i_phase_current_b > imax_nxt) imax_nxt = i_phase_current_b;
    if (i_phase_current_c > imax_nxt) imax_nxt = i_phase_current_c;
  end

  // The supervised value is sampled on the tick so all decisions see one snapshot.
  // The valid flag stops the zero reset value from passing for an idle sample.
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      imax_r     <= '0;
      imax_vld_r <= 1'b0;
    end else if (i_meas_tick) begin
      imax_r     <= imax_nxt;
      imax_vld_r <= 1'b1;
    end
  end

  // Primary scaling; the product is kept wide and truncated after the shift.
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      idle_prim_r   <= '0;
      pickup_prim_r <= '0;
      max_ticks_r   <= '0;
    end else begin
      idle_prim_r   <= CW'((32'(idle_r) * 32'(i_nominal_primary_a)) >> `CLDI_REL_FRAC);
      pickup_prim_r <= CW'((32'(pickup_r) * 32'(i_nominal_primary_a)) >> `CLDI_REL_FRAC);
      max_ticks_r   <= TW'(32'(max_time_r) * 32'(TICKS_PER_S));
    end
  end

  // Per-phase second-harmonic comparison.
  assign harm_ph[0] = i_harm_ratio_a;
  assign harm_ph[1] = i_harm_ratio_b;
  assign harm_ph[2] = i_harm_ratio_c;
  for (genvar p = 0; p < 3; p++) begin : g_harm
    assign harm_over[p] = harm_ph[p] > harm_thr_r;
  end

  assign all_idle     = imax_vld_r && (imax_r < idle_r);
  assign above_pickup = imax_r >= pickup_r;
  // A rise only counts from the armed states, so never-idle current cannot start.
  assign trigger = i_meas_tick && above_pickup &&
                   (arm_r == CLDI_ARMED || arm_r == CLDI_RISING);

  // Arming sequence: idle arms, a prompt rise triggers, a slow one is abandoned.
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      arm_r <= CLDI_UNARMED;
    end else if (i_meas_tick) begin
      unique case (arm_r)
        CLDI_UNARMED: if (all_idle) arm_r <= CLDI_ARMED;
        CLDI_ARMED: begin
          if (above_pickup) arm_r <= CLDI_ENGAGED;
          else if (!all_idle) arm_r <= CLDI_RISING;
        end
        CLDI_RISING: begin
          if (above_pickup) arm_r <= CLDI_ENGAGED;
          else if (all_idle) arm_r <= CLDI_ARMED;
          else if (rise_cnt_r >= RISE_LIM) arm_r <= CLDI_UNARMED;
        end
        // Once both functions have ended, a fresh idle period is needed.
        CLDI_ENGAGED: begin
          if (!cold_if.active && !inr_if.active && !above_pickup) begin
            arm_r <= all_idle ? CLDI_ARMED : CLDI_UNARMED;
          end
        end
      endcase
    end
  end

  // Rise timer in ticks, restarted by every idle sample.
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rise_cnt_r <= '0;
    end else if (i_meas_tick) begin
      if (all_idle || arm_r != CLDI_RISING) rise_cnt_r <= '0;
      else if (rise_cnt_r < RISE_LIM) rise_cnt_r <= rise_cnt_r + 1'b1;
    end
  end

  // Counts the first power cycle after the rise; harmonics are unreliable before.
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      cycle_cnt_r <= '0;
      harm_seen_r <= 1'b0;
    end else if (trigger) begin
      cycle_cnt_r <= '0;
      harm_seen_r <= 1'b0;
    end else if (i_meas_tick && inr_if.active) begin
      if (cycle_cnt_r < CYCLE_LIM) cycle_cnt_r <= cycle_cnt_r + 1'b1;
      if (cycle_cnt_r + 1'b1 >= CYCLE_LIM && |harm_over) harm_seen_r <= 1'b1;
    end
  end

  assign in_first_cycle = cycle_cnt_r < CYCLE_LIM;
  // Zero threshold disables the harmonic condition entirely.
  assign harm_ok = (harm_thr_r == '0) || in_first_cycle ||
                   harm_seen_r || (|harm_over);

  // Stage controls; both start on the same rise.
  assign cold_if.tick      = i_meas_tick;
  assign cold_if.start     = trigger;
  assign cold_if.keep      = above_pickup;
  assign cold_if.max_ticks = max_ticks_r;
  assign inr_if.tick       = i_meas_tick;
  assign inr_if.start      = trigger;
  assign inr_if.keep       = above_pickup && harm_ok;
  assign inr_if.max_ticks  = max_ticks_r;

  cldi_stage #(.TW(TW)) u_cold (
    .i_ref_clk (i_ref_clk),
    .i_resetn  (i_resetn),
    .sif       (cold_if.stage)
  );

  cldi_stage #(.TW(TW)) u_inrush (
    .i_ref_clk (i_ref_clk),
    .i_resetn  (i_resetn),
    .sif       (inr_if.stage)
  );

  // Observed values and settings for display.
  assign o_max_phase_current         = imax_r;
  assign o_idle_primary              = idle_prim_r;
  assign o_pickup_primary            = pickup_prim_r;
  assign o_idle_setting              = idle_r;
  assign o_pickup_setting            = pickup_r;
  assign o_max_active_time           = max_time_r;
  assign o_second_harmonic_threshold = harm_thr_r;
  assign o_cold_load_status          = cold_if.status;
  assign o_inrush_status             = inr_if.status;
  assign o_cold_load                 = cold_if.active;
  assign o_inrush                    = inr_if.active;

  // Matrix routing; bit 0/1 output matrix, bit 2/3 blocking matrix.
  assign o_out_matrix_cold_load   = cold_if.active && i_route_en[0];
  assign o_out_matrix_inrush      = inr_if.active && i_route_en[1];
  assign o_block_matrix_cold_load = cold_if.active && i_route_en[2];
  assign o_block_matrix_inrush    = inr_if.active && i_route_en[3];

endmodule

// File: rtl/cldi_stage.sv
`timescale 1ns/1ps
module cldi_stage
  import cldi_pkg::*;
#(
  parameter int TW = 32
) (
  input  wire logic   i_ref_clk,
  input  wire logic   i_resetn,
  cldi_stage_if.stage sif
);

  logic [TW-1:0] elapsed_r;
  cldi_status_t  status_r;

  // Start holds while the keep condition stands; the max time turns it into trip.
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      status_r <= CLDI_INACTIVE;
    end else begin
      unique case (status_r)
        CLDI_INACTIVE: if (sif.start) status_r <= CLDI_START;
        CLDI_START: begin
          if (!sif.keep) status_r <= CLDI_INACTIVE;
          else if (sif.tick && elapsed_r + 1'b1 >= sif.max_ticks) begin
            status_r <= CLDI_TRIP;
          end
        end
        // Trip is shown until the condition that raised it has gone.
        CLDI_TRIP: if (!sif.keep) status_r <= CLDI_INACTIVE;
      endcase
    end
  end

  // Elapsed ticks since start; cleared whenever the stage is not running.
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      elapsed_r <= '0;
    end else if (status_r != CLDI_START) begin
      elapsed_r <= '0;
    end else if (sif.tick) begin
      elapsed_r <= elapsed_r + 1'b1;
    end
  end

  assign sif.status = status_r;
  assign sif.active = (status_r == CLDI_START);

endmodule

// File: test/cldi_asserts.sv
`timescale 1ns/1ps
// Pin-level checks on the detector; everything here runs on one clock.
module cldi_asserts
  import cldi_pkg::*;
(
  input wire logic         i_ref_clk,
  input wire logic         i_resetn,
  input wire logic         i_meas_tick,
  input wire logic [15:0]  i_phase_current_a,
  input wire logic [15:0]  i_phase_current_b,
  input wire logic [15:0]  i_phase_current_c,
  input wire logic [7:0]   i_harm_ratio_a,
  input wire logic [7:0]   i_harm_ratio_b,
  input wire logic [7:0]   i_harm_ratio_c,
  input wire logic [15:0]  i_nominal_primary_a,
  input wire logic         i_password_ok,
  input wire logic         i_set_we,
  input wire logic [15:0]  i_set_idle,
  input wire logic [3:0]   i_route_en,
  input wire logic [15:0]  o_max_phase_current,
  input wire logic [15:0]  o_idle_primary,
  input wire logic [15:0]  o_idle_setting,
  input wire logic [7:0]   o_second_harmonic_threshold,
  input wire cldi_status_t o_cold_load_status,
  input wire cldi_status_t o_inrush_status,
  input wire logic         o_cold_load,
  input wire logic         o_inrush,
  input wire logic         o_out_matrix_cold_load,
  input wire logic         o_out_matrix_inrush,
  input wire logic         o_block_matrix_cold_load,
  input wire logic         o_block_matrix_inrush
);
  logic [15:0] ab_max;
  logic [15:0] phase_max;
  logic [31:0] idle_prod;
  logic [23:0] harm_all;
  // Reference values built from the pins, compared one edge later.
  assign ab_max    = (i_phase_current_a > i_phase_current_b) ?
                     i_phase_current_a : i_phase_current_b;
  assign phase_max = (ab_max > i_phase_current_c) ? ab_max : i_phase_current_c;
  assign idle_prod = o_idle_setting * i_nominal_primary_a;
  // Harmonic ratios feed the inrush hold directly, so a change of them may move it.
  assign harm_all  = {i_harm_ratio_a, i_harm_ratio_b, i_harm_ratio_c};

  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_resetn);

  sequence s_write;
    i_set_we && i_password_ok;
  endsequence

  route_map_a: assert property (
    {o_block_matrix_inrush, o_block_matrix_cold_load, o_out_matrix_inrush, o_out_matrix_cold_load}
    == (i_route_en & {o_inrush, o_cold_load, o_inrush, o_cold_load}))
    else $error("matrix routing mismatch");
  status_level_a: assert property (
    o_cold_load == (o_cold_load_status == CLDI_START) &&
    o_inrush == (o_inrush_status == CLDI_START))
    else $error("signal level disagrees with status");
  settings_take_a: assert property (
    s_write |=> o_idle_setting == $past(i_set_idle))
    else $error("accepted write not applied");
  settings_hold_a: assert property (
    !(i_set_we && i_password_ok) |=> $stable(o_idle_setting))
    else $error("setting changed without password write");
  primary_scale_a: assert property (
    $past(i_resetn) |-> o_idle_primary == $past(idle_prod[23:8]))
    else $error("primary idle value wrong");
  max_sample_a: assert property (
    i_meas_tick |=> o_max_phase_current == $past(phase_max))
    else $error("supervised current not the phase maximum");
  // Status moves one edge after a tick or a harmonic change, or two after a tick or a write.
  tick_only_a: assert property (
    !$past(i_meas_tick) && !$past(i_meas_tick, 2) &&
    !$past(i_set_we && i_password_ok, 2) && $past(harm_all) == $past(harm_all, 2)
    |-> $stable(o_cold_load_status) && $stable(o_inrush_status))
    else $error("status moved without a tick");
  zero_thr_a: assert property (
    o_second_harmonic_threshold == 8'h00 |-> o_inrush_status == o_cold_load_status)
    else $error("inrush differs from cold load at zero threshold");
endmodule

bind cldi_detector cldi_asserts u_asserts (
  .i_ref_clk, .i_resetn, .i_meas_tick, .i_phase_current_a, .i_phase_current_b,
  .i_phase_current_c, .i_harm_ratio_a, .i_harm_ratio_b, .i_harm_ratio_c,
  .i_nominal_primary_a, .i_password_ok, .i_set_we, .i_set_idle,
  .i_route_en, .o_max_phase_current, .o_idle_primary, .o_idle_setting,
  .o_second_harmonic_threshold, .o_cold_load_status, .o_inrush_status, .o_cold_load,
  .o_inrush, .o_out_matrix_cold_load, .o_out_matrix_inrush, .o_block_matrix_cold_load,
  .o_block_matrix_inrush
);

// File: test/cldi_frontend_model.sv
`timescale 1ns/1ps
// Measurement front end: a periodic tick and magnitudes refreshed behind it.
module cldi_frontend_model #(
  parameter int TICK_CLKS = 8
) (
  input  wire logic        i_ref_clk,
  input  wire logic        i_resetn,
  input  wire logic [15:0] i_lvl_a,
  input  wire logic [15:0] i_lvl_b,
  input  wire logic [15:0] i_lvl_c,
  input  wire logic [7:0]  i_harm,
  output logic             o_tick,
  output logic [15:0]      o_cur_a,
  output logic [15:0]      o_cur_b,
  output logic [15:0]      o_cur_c,
  output logic [7:0]       o_harm_a
);
  logic [7:0] cnt_r;
  // Tick divider; the tick is a single-cycle pulse.
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      cnt_r  <= 8'h00;
      o_tick <= 1'h0;
    end else begin
      cnt_r  <= (cnt_r == 8'(TICK_CLKS - 1)) ? 8'h00 : cnt_r + 8'h01;
      o_tick <= (cnt_r == 8'(TICK_CLKS - 1));
    end
  end
  // Values change only after a tick or during reset, so each is a full period old when sampled.
  always_ff @(posedge i_ref_clk) begin
    if (!i_resetn || o_tick) begin
      o_cur_a  <= i_lvl_a;
      o_cur_b  <= i_lvl_b;
      o_cur_c  <= i_lvl_c;
      o_harm_a <= i_harm;
    end
  end
endmodule

// File: test/cold_load_inrush_detector_tb_top.sv
`timescale 1ns/1ps
// Drives settings and phase levels, then checks both detector states.
module cold_load_inrush_detector_tb_top;
  import cldi_pkg::*;
  logic         clk = 1'h0;
  logic         rstn = 1'h0;
  logic         tick, we, pw, om_c, om_i, bm_c, bm_i;
  logic [15:0]  lvl_a, lvl_b, lvl_c, cur_a, cur_b, cur_c, s_idle, s_pick, s_mt;
  logic [15:0]  max_cur, idle_pri, pick_pri, idle_set, mt_out, pick_set;
  logic [7:0]   harm, hr_a, s_thr;
  logic [3:0]   route;
  cldi_status_t cold_st, inr_st;
  int           failures, compares, cycles;

  // Fast ticks and two ticks per second keep the timeouts short.
  cldi_frontend_model fe (.i_ref_clk(clk), .i_resetn(rstn), .i_lvl_a(lvl_a),
    .i_lvl_b(lvl_b), .i_lvl_c(lvl_c), .i_harm(harm), .o_tick(tick),
    .o_cur_a(cur_a), .o_cur_b(cur_b), .o_cur_c(cur_c), .o_harm_a(hr_a));
  cldi_detector #(.TICKS_PER_S(2)) uut (
    .i_ref_clk(clk), .i_resetn(rstn), .i_meas_tick(tick),
    .i_phase_current_a(cur_a), .i_phase_current_b(cur_b), .i_phase_current_c(cur_c),
    .i_harm_ratio_a(hr_a), .i_harm_ratio_b(8'h00), .i_harm_ratio_c(8'h00),
    .i_nominal_primary_a(16'h0064), .i_password_ok(pw), .i_set_we(we),
    .i_set_idle(s_idle), .i_set_pickup(s_pick), .i_set_max_active_time(s_mt),
    .i_set_second_harmonic_threshold(s_thr), .i_route_en(route),
    .o_max_phase_current(max_cur), .o_idle_primary(idle_pri),
    .o_pickup_primary(pick_pri), .o_idle_setting(idle_set), .o_pickup_setting(pick_set),
    .o_max_active_time(mt_out), .o_second_harmonic_threshold(),
    .o_cold_load_status(cold_st), .o_inrush_status(inr_st), .o_cold_load(),
    .o_inrush(), .o_out_matrix_cold_load(om_c), .o_out_matrix_inrush(om_i),
    .o_block_matrix_cold_load(bm_c), .o_block_matrix_inrush(bm_i));

  always #4 clk = ~clk;

  task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("BAD %0t value %h want %h", $time, got, exp);
    end
  endtask
  task automatic st(input cldi_status_t c, input cldi_status_t i);
    compares++;
    if (cold_st !== c || inr_st !== i) begin
      failures++;
      $display("BAD %0t status %0d/%0d want %0d/%0d", $time, cold_st, inr_st, c, i);
    end
  endtask
  task automatic end_of_test;
    $display("failures=%0d compares=%0d", failures, compares);
    if (failures == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // One write strobe carries all four settings; wait for the primary values.
  task automatic wr(input logic [15:0] i, p, t, input logic [7:0] h, input logic ok);
    {s_idle, s_pick, s_mt, s_thr, pw, we} = {i, p, t, h, ok, 1'h1};
    @(posedge clk);
    #1 we = 1'h0;
    repeat (2) @(posedge clk);
    #1;
  endtask
  // Status moves one cycle after a tick, so look just after that edge.
  task automatic lvl(input logic [15:0] a, b, c, input logic [7:0] h, input int n);
    {lvl_a, lvl_b, lvl_c, harm} = {a, b, c, h};
    repeat (n) @(posedge tick);
    @(posedge clk);
    #1;
  endtask
  task automatic flat(input logic [15:0] v, input logic [7:0] h, input int n);
    lvl(v, v, v, h, n);
  endtask

  // A hung handshake ends the run through the normal report.
  always @(posedge clk) begin
    cycles++;
    if (cycles > 4000) begin
      failures++;
      $display("BAD %0t timeout", $time);
      end_of_test();
    end
  end

  initial begin
    {lvl_a, lvl_b, lvl_c, harm, we, pw, route} = {48'h010001000100, 8'h00, 2'h0, 4'hF};
    {s_idle, s_pick, s_mt, s_thr} = 56'h0;
    repeat (12) @(posedge clk);
    #1 rstn = 1'h1;
    chk16(idle_set, 16'h0020);
    chk16(mt_out, 16'h0001);
    st(CLDI_INACTIVE, CLDI_INACTIVE);
    wr(16'h0040, 16'h0200, 16'h0009, 8'h00, 1'h0);
    chk16(idle_set, 16'h0020);
    chk16(pick_pri, 16'h0096);
    wr(16'h0030, 16'h0180, 16'h0005, 8'h14, 1'h1);
    chk16(mt_out, 16'h0005);
    chk16(pick_set, 16'h0180);
    chk16(idle_pri, 16'h0012);
    lvl(16'h0200, 16'h0100, 16'h0300, 8'h30, 4);
    chk16(max_cur, 16'h0300);
    st(CLDI_INACTIVE, CLDI_INACTIVE);
    flat(16'h0010, 8'h00, 4);
    lvl(16'h0200, 16'h0280, 16'h0100, 8'h30, 4);
    chk16(max_cur, 16'h0280);
    st(CLDI_START, CLDI_START);
    chk16({12'h000, bm_i, bm_c, om_i, om_c}, 16'h000F);
    lvl(16'h0200, 16'h0280, 16'h0100, 8'h30, 12);
    st(CLDI_TRIP, CLDI_TRIP);
    flat(16'h0100, 8'h30, 4);
    st(CLDI_INACTIVE, CLDI_INACTIVE);
    flat(16'h0010, 8'h00, 4);
    flat(16'h0100, 8'h00, 12);
    flat(16'h0200, 8'h30, 4);
    st(CLDI_INACTIVE, CLDI_INACTIVE);
    flat(16'h0010, 8'h00, 4);
    flat(16'h0100, 8'h00, 2);
    flat(16'h0200, 8'h30, 4);
    st(CLDI_START, CLDI_START);
    flat(16'h0100, 8'h30, 4);
    st(CLDI_INACTIVE, CLDI_INACTIVE);
    route = 4'h3;
    flat(16'h0010, 8'h00, 4);
    flat(16'h0200, 8'h05, 8);
    st(CLDI_START, CLDI_INACTIVE);
    chk16({12'h000, bm_i, bm_c, om_i, om_c}, 16'h0001);
    flat(16'h0100, 8'h00, 4);
    wr(16'h0030, 16'h0180, 16'h0005, 8'h00, 1'h1);
    flat(16'h0010, 8'h00, 4);
    flat(16'h0200, 8'h05, 8);
    st(CLDI_START, CLDI_START);
    end_of_test();
  end
endmodule
